// ==== hdl/pin_sync_defs.vh ====
// Purpose: register map, field positions, reset values and codes for
//          the pin, sync and fault control block
// Assumes: plain strobe register port, one 50 MHz clock
// Notes:   definitions only
`ifndef PIN_SYNC_DEFS_VH
`define PIN_SYNC_DEFS_VH

// register offsets
`define ADDR_IO_PIN_CONFIG 8'h06
`define ADDR_IRQ_STATUS 8'h08
`define ADDR_IRQ_MASK 8'h09
`define ADDR_SEQ_MODE 8'h0A
`define ADDR_SEQ_STATE 8'h0B

// io_pin_config layout
`define IO_PIN_CONFIG_RST 16'h0800
`define BIT_RESERVED 15
`define BIT_PD_SWITCH 14
`define BIT_EXTRA_OUT_EN 13
`define BIT_MUX_CTRL_EN 12
`define BIT_SYNC_EN 11
`define FAULT_MODE_HI 10
`define FAULT_MODE_LO 9
`define BIT_FAULT_DATA 8

// fault pin function codes
`define FAULT_OFF 2'h0
`define FAULT_INPUT 2'h1
`define FAULT_OPEN_DRAIN 2'h2
`define FAULT_GP_OUT 2'h3

// seq_mode layout
`define BIT_DEFERRED 0
`define SETTLE_HI 15
`define SETTLE_LO 8
`define SEQ_MODE_RST 16'h0000

// interrupt event bits
`define IRQ_PASS_DONE 0
`define IRQ_SYNC_LOW 1
`define IRQ_CONV_ERR 2
`define IRQ_CHAN_SWITCH 3
`define IRQ_W 4

// synchroniser idle levels
`define PIN_IDLE 2'h3

`endif

// ==== hdl/pin_sync3.v ====
// Purpose: three-stage input synchroniser with agreement filter
// Assumes: inputs are asynchronous pins
// Notes:   output moves only once stages two and three agree
`timescale 1ns/100ps
module pin_sync3 #(
    parameter W = 2,
    parameter [W-1:0] RST_VAL = {W{1'b1}}
) (
    input wire i_clk_sys, // system clock
    input wire i_rst, // async reset, active high
    input wire i_ce, // clock enable
    input wire [W-1:0] i_pin, // raw pin levels
    output reg [W-1:0] o_level_q // filtered level
);
    genvar g;
    generate
        for (g = 0; g < W; g = g + 1) begin : bit_sync
            reg s1_q;
            reg s2_q;
            reg s3_q;
            // first stage feeds only the second, to contain metastability
            always @(posedge i_clk_sys or posedge i_rst) begin
                if (i_rst) begin
                    s1_q <= RST_VAL[g];
                    s2_q <= RST_VAL[g];
                    s3_q <= RST_VAL[g];
                    o_level_q[g] <= RST_VAL[g];
                end else if (i_ce) begin
                    s1_q <= i_pin[g];
                    s2_q <= s1_q;
                    s3_q <= s2_q;
                    if (s2_q == s3_q) begin
                        o_level_q[g] <= s3_q;
                    end
                end
            end
        end
    endgenerate
endmodule

// ==== hdl/settle_timer.v ====
// Purpose: counts the settling delay after an external mux switch
// Assumes: one start pulse per switch
// Notes:   a new start restarts the count; zero length still takes
//          two cycles so the done pulse is always registered
`timescale 1ns/100ps
module settle_timer #(
    parameter DW = 8
) (
    input wire i_clk_sys, // system clock
    input wire i_rst, // async reset, active high
    input wire i_ce, // clock enable
    input wire i_start, // start pulse
    input wire [DW-1:0] i_len, // delay in clock cycles
    output reg o_done_q // one-cycle done pulse
);
    reg [DW-1:0] cnt_q;
    reg busy_q;

    // down counter with registered completion
    always @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            cnt_q <= {DW{1'b0}};
            busy_q <= 1'b0;
            o_done_q <= 1'b0;
        end else if (i_ce) begin
            o_done_q <= 1'b0;
            if (i_start) begin
                cnt_q <= i_len;
                busy_q <= 1'b1;
            end else if (busy_q) begin
                if (cnt_q == {DW{1'b0}}) begin
                    busy_q <= 1'b0;
                    o_done_q <= 1'b1;
                end else begin
                    cnt_q <= cnt_q - 1'b1;
                end
            end
        end
    end
endmodule

// ==== hdl/pin_sync_error_control.v ====
// Purpose: config register, channel sequencer with external mux
//          select, sync input handling and fault pin control
// Assumes: conversion core on the same clock reports i_conv_done
// Notes:   register bits 7..0 of the config word are not held here
//
// The strobed register port was decided locally.
`timescale 1ns/100ps
`include "pin_sync_defs.vh"
module pin_sync_error_control #(
    parameter NCH = 16,
    parameter CW = 4,
    parameter PW = 4,
    parameter EW = 4,
    parameter DW = 8
) (
    input wire i_clk_sys, // system clock, 50 MHz
    input wire i_rst, // async reset, active high
    input wire i_ce, // clock enable, freezes state when low
    input wire [7:0] i_addr, // register address
    input wire [15:0] i_wdata, // register write data
    input wire i_wr, // write strobe
    input wire i_rd, // read strobe
    output reg [15:0] o_rdata, // read data, cycle after strobe
    input wire [NCH-1:0] i_chan_enable, // per-channel enables
    input wire [NCH*PW-1:0] i_chan_pair, // per-channel input pair
    input wire i_conv_done, // conversion finished pulse
    input wire i_other_error, // other converter error sources
    input wire [EW-1:0] i_status_errors, // other status error bits
    input wire i_sync_n, // sync pin, low active
    input wire i_fault_pin_in, // fault pin level
    output reg o_fault_pin_out, // fault pin drive level
    output reg o_fault_pin_oe_n, // fault pin drive enable, low
    output reg o_power_down_switch_on, // power-down switch sink
    output reg o_general_pin_zero, // general pin zero level
    output reg o_general_pin_one, // general pin one level
    output reg o_general_pins_oe_n, // general pins drive, low
    output reg o_extra_output_two, // extra output two level
    output reg o_extra_output_three, // extra output three level
    output reg o_extra_outputs_oe_n, // extra outputs drive, low
    output reg [CW-1:0] o_active_chan, // active channel index
    output reg [PW-1:0] o_ain_pair, // input pair of active channel
    output reg o_conv_start, // start conversion pulse
    output reg o_conv_reset, // hold modulator and filter
    output reg o_conv_error, // converter error status bit
    output reg o_irq // level interrupt
);
    // sequencer states
    localparam [3:0] ST_IDLE = 4'h1;
    localparam [3:0] ST_SETTLE = 4'h2;
    localparam [3:0] ST_CONV = 4'h4;
    localparam [3:0] ST_WAIT = 4'h8;

    // held config bits 14..8; bit 15 reads zero
    reg [6:0] cfg_q;
    reg [15:0] seq_mode_q;
    reg [`IRQ_W-1:0] irq_status_q;
    reg [`IRQ_W-1:0] irq_mask_q;
    reg [3:0] state_q;
    reg [CW-1:0] chan_q;
    reg settle_go_q;
    reg sync_n_prev_q;
    reg conv_err_prev_q;
    wire [1:0] pins_s;
    wire sync_n_s;
    wire fault_s;
    wire settle_done;
    wire [15:0] cfg_word;
    wire pd_switch;
    wire extra_en;
    wire mux_en;
    wire sync_en;
    wire [1:0] fault_mode;
    wire fault_data;
    wire deferred_eff;
    wire hold_reset;
    wire any_enabled;
    wire any_error;
    wire [DW-1:0] settle_len;
    reg [CW-1:0] chan_next;
    reg [CW-1:0] chan_first;
    reg wrap_next;
    reg [`IRQ_W-1:0] irq_event;
    // reset image, cut to the held bits 14..8 on purpose
    localparam [15:0] CFG_RST = `IO_PIN_CONFIG_RST;
    reg conv_err_d;
    reg [15:0] rdata_d;

    // both pins come from outside the clock domain
    pin_sync3 #(
        .W(2),
        .RST_VAL(`PIN_IDLE)
    ) u_pin_sync (
        .i_clk_sys(i_clk_sys),
        .i_rst(i_rst),
        .i_ce(i_ce),
        .i_pin({i_sync_n, i_fault_pin_in}),
        .o_level_q(pins_s)
    );
    assign sync_n_s = pins_s[1];
    assign fault_s = pins_s[0];

    // config field decode
    assign cfg_word = {1'b0, cfg_q, 8'h00};
    assign pd_switch = cfg_word[`BIT_PD_SWITCH];
    assign extra_en = cfg_word[`BIT_EXTRA_OUT_EN];
    assign mux_en = cfg_word[`BIT_MUX_CTRL_EN];
    assign sync_en = cfg_word[`BIT_SYNC_EN];
    assign fault_mode = cfg_word[`FAULT_MODE_HI:`FAULT_MODE_LO];
    assign fault_data = cfg_word[`BIT_FAULT_DATA];

    // deferred mode only makes sense with two or more channels enabled
    assign deferred_eff = seq_mode_q[`BIT_DEFERRED] &
        (|(i_chan_enable & (i_chan_enable - 1'b1)));
    assign hold_reset = sync_en & ~deferred_eff & ~sync_n_s;
    assign any_enabled = |i_chan_enable;
    assign any_error = o_conv_error | (|i_status_errors);

    // settle delay only matters when an external mux was switched
    assign settle_len = mux_en ?
        seq_mode_q[`SETTLE_HI:`SETTLE_LO] : {DW{1'b0}};

    settle_timer #(
        .DW(DW)
    ) u_settle (
        .i_clk_sys(i_clk_sys),
        .i_rst(i_rst),
        .i_ce(i_ce),
        .i_start(settle_go_q),
        .i_len(settle_len),
        .o_done_q(settle_done)
    );

    // next enabled channel after chan_q, wrapping within NCH entries
    always @* begin : find_next
        integer i;
        integer idx;
        reg found;
        i = 0;
        idx = 0;
        found = 1'b0;
        chan_next = chan_q;
        wrap_next = 1'b0;
        for (i = 1; i <= NCH; i = i + 1) begin
            idx = chan_q + i;
            if (idx >= NCH) begin
                idx = idx - NCH;
            end
            if (!found && i_chan_enable[idx]) begin
                found = 1'b1;
                chan_next = idx[CW-1:0];
                wrap_next = (idx <= chan_q);
            end
        end
    end

    // lowest enabled channel, where each pass begins
    always @* begin : find_first
        integer j;
        reg hit;
        j = 0;
        hit = 1'b0;
        chan_first = {CW{1'b0}};
        for (j = 0; j < NCH; j = j + 1) begin
            if (!hit && i_chan_enable[j]) begin
                hit = 1'b1;
                chan_first = j[CW-1:0];
            end
        end
    end

    // sequencer; sync either holds it in reset or defers a switch
    always @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            state_q <= ST_IDLE;
            chan_q <= {CW{1'b0}};
            settle_go_q <= 1'b0;
            o_conv_start <= 1'b0;
            o_conv_reset <= 1'b0;
        end else if (i_ce) begin
            settle_go_q <= 1'b0;
            o_conv_start <= 1'b0;
            o_conv_reset <= hold_reset;
            if (hold_reset || !any_enabled) begin
                state_q <= ST_IDLE;
            end else begin
                case (state_q)
                    ST_IDLE: begin
                        chan_q <= chan_first;
                        settle_go_q <= 1'b1;
                        state_q <= ST_SETTLE;
                    end
                    ST_SETTLE: begin
                        if (settle_done) begin
                            o_conv_start <= 1'b1;
                            state_q <= ST_CONV;
                        end
                    end
                    ST_CONV: begin
                        if (i_conv_done) begin
                            if (deferred_eff && !sync_n_s) begin
                                state_q <= ST_WAIT;
                            end else begin
                                chan_q <= chan_next;
                                settle_go_q <= 1'b1;
                                state_q <= ST_SETTLE;
                            end
                        end
                    end
                    ST_WAIT: begin
                        if (sync_n_s) begin
                            chan_q <= chan_next;
                            settle_go_q <= 1'b1;
                            state_q <= ST_SETTLE;
                        end
                    end
                    default: begin
                        state_q <= ST_IDLE;
                    end
                endcase
            end
        end
    end

    // converter error: in input mode the inverted fault input joins the other sources
    always @* begin
        conv_err_d = i_other_error;
        if (fault_mode == `FAULT_INPUT) begin
            conv_err_d = i_other_error | ~fault_s;
        end
    end

    // interrupt events
    always @* begin
        irq_event = {`IRQ_W{1'b0}};
        irq_event[`IRQ_PASS_DONE] = state_q[2] & i_conv_done & wrap_next &
            ~hold_reset;
        irq_event[`IRQ_SYNC_LOW] = sync_en & sync_n_prev_q & ~sync_n_s;
        irq_event[`IRQ_CONV_ERR] = conv_err_d & ~conv_err_prev_q;
        irq_event[`IRQ_CHAN_SWITCH] = settle_go_q;
    end

    // register writes; a new event beats a clear in the same cycle
    always @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            cfg_q <= CFG_RST[14:8];
            seq_mode_q <= `SEQ_MODE_RST;
            irq_status_q <= {`IRQ_W{1'b0}};
            irq_mask_q <= {`IRQ_W{1'b0}};
            sync_n_prev_q <= 1'b1;
            conv_err_prev_q <= 1'b0;
        end else if (i_ce) begin
            sync_n_prev_q <= sync_n_s;
            conv_err_prev_q <= conv_err_d;
            if (i_wr && i_addr == `ADDR_IO_PIN_CONFIG) begin
                cfg_q <= i_wdata[14:8];
            end
            if (i_wr && i_addr == `ADDR_SEQ_MODE) begin
                seq_mode_q <= i_wdata;
            end
            if (i_wr && i_addr == `ADDR_IRQ_MASK) begin
                irq_mask_q <= i_wdata[`IRQ_W-1:0];
            end
            if (i_wr && i_addr == `ADDR_IRQ_STATUS) begin
                irq_status_q <= (irq_status_q & ~i_wdata[`IRQ_W-1:0]) |
                    irq_event;
            end else begin
                irq_status_q <= irq_status_q | irq_event;
            end
        end
    end

    // read mux; the data bit shows the pin while it is an input
    always @* begin
        rdata_d = 16'h0000;
        case (i_addr)
            `ADDR_IO_PIN_CONFIG: begin
                rdata_d = cfg_word;
                if (fault_mode == `FAULT_INPUT) begin
                    rdata_d[`BIT_FAULT_DATA] = fault_s;
                end
            end
            `ADDR_IRQ_STATUS: rdata_d[`IRQ_W-1:0] = irq_status_q;
            `ADDR_IRQ_MASK: rdata_d[`IRQ_W-1:0] = irq_mask_q;
            `ADDR_SEQ_MODE: rdata_d = seq_mode_q;
            `ADDR_SEQ_STATE: begin
                rdata_d[CW-1:0] = chan_q;
                rdata_d[8] = o_conv_error;
                rdata_d[9] = ~sync_n_s;
                rdata_d[10] = o_conv_reset;
                rdata_d[11] = state_q[3];
            end
            default: rdata_d = 16'h0000;
        endcase
    end

    // read data stands only in the cycle after the strobe
    always @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            o_rdata <= 16'h0000;
        end else if (i_ce) begin
            o_rdata <= i_rd ? rdata_d : 16'h0000;
        end
    end

    // pin outputs all registered so no decode glitches reach pins
    always @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            o_fault_pin_out <= 1'b0;
            o_fault_pin_oe_n <= 1'b1;
            o_power_down_switch_on <= 1'b0;
            o_general_pin_zero <= 1'b0;
            o_general_pin_one <= 1'b0;
            o_general_pins_oe_n <= 1'b1;
            o_extra_output_two <= 1'b0;
            o_extra_output_three <= 1'b0;
            o_extra_outputs_oe_n <= 1'b1;
            o_active_chan <= {CW{1'b0}};
            o_ain_pair <= {PW{1'b0}};
            o_conv_error <= 1'b0;
            o_irq <= 1'b0;
        end else if (i_ce) begin
            o_power_down_switch_on <= pd_switch;
            o_active_chan <= chan_q;
            o_ain_pair <= i_chan_pair[chan_q*PW +: PW];
            o_conv_error <= conv_err_d;
            o_irq <= |(irq_status_q & irq_mask_q);
            // select lines follow the channel in the same cycle
            o_general_pins_oe_n <= ~mux_en;
            o_general_pin_zero <= mux_en & chan_q[0];
            o_general_pin_one <= mux_en & chan_q[1];
            o_extra_outputs_oe_n <= ~(extra_en | mux_en);
            o_extra_output_two <= mux_en & chan_q[2];
            o_extra_output_three <= mux_en & chan_q[3];
            case (fault_mode)
                `FAULT_OPEN_DRAIN: begin
                    o_fault_pin_out <= 1'b0;
                    o_fault_pin_oe_n <= ~any_error;
                end
                `FAULT_GP_OUT: begin
                    o_fault_pin_out <= fault_data;
                    o_fault_pin_oe_n <= 1'b0;
                end
                default: begin
                    o_fault_pin_out <= 1'b0;
                    o_fault_pin_oe_n <= 1'b1;
                end
            endcase
        end
    end
endmodule

// ==== verification/conv_side_model.sv ====
// Purpose: far side: conversion core and the wired fault line
// Assumes: shares the block clock
// Notes:   i_slow stretches conversions to exercise waiting states
`timescale 1ns/100ps
module conv_side_model (
    input wire i_clk_sys, // system clock
    input wire i_rst, // async reset, active high
    input wire i_slow, // long conversion when high
    input wire i_conv_start, // start pulse from block
    output reg o_conv_done, // done pulse to block
    input wire i_pin_out, // block fault drive level
    input wire i_pin_oe_n, // block fault drive enable, low
    input wire i_other_low, // another device pulls the line low
    output wire o_pin_level // resolved fault line
);
    reg [3:0] cnt_q;
    // released line floats to the shared pull-up level
    assign o_pin_level = i_other_low ? 1'b0 :
        (i_pin_oe_n ? 1'b1 : i_pin_out);
    // done comes 3 cycles after each start, or 11 with i_slow high, never early
    always @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            cnt_q <= 4'h0;
            o_conv_done <= 1'b0;
        end else begin
            o_conv_done <= (cnt_q == 4'h1);
            if (i_conv_start) begin
                cnt_q <= i_slow ? 4'hA : 4'h2;
            end else if (cnt_q != 4'h0) begin
                cnt_q <= cnt_q - 4'h1;
            end
        end
    end
endmodule

// ==== verification/pin_sync_error_control_properties.sv ====
// Purpose: port-level checks for pin, sync and fault control
// Assumes: clock enable drops only while the sequencer is held idle
// Notes:   pin outputs follow a config write two edges later
`timescale 1ns/100ps
module pin_sync_error_control_props #(
    parameter NCH = 16,
    parameter CW = 4,
    parameter PW = 4
) (
    input wire i_clk_sys, // system clock
    input wire i_rst, // async reset, active high
    input wire [7:0] i_addr, // register address
    input wire [15:0] i_wdata, // write data
    input wire i_wr, // write strobe
    input wire [NCH-1:0] i_chan_enable, // channel enables
    input wire [NCH*PW-1:0] i_chan_pair, // channel input pairs
    input wire o_power_down_switch_on, // switch sink
    input wire o_general_pin_zero, // select bit 0
    input wire o_general_pin_one, // select bit 1
    input wire o_general_pins_oe_n, // general drive, low
    input wire o_extra_output_two, // select bit 2
    input wire o_extra_output_three, // select bit 3
    input wire o_extra_outputs_oe_n, // extra drive, low
    input wire [CW-1:0] o_active_chan, // active channel
    input wire [PW-1:0] o_ain_pair, // active input pair
    input wire o_conv_start, // start pulse
    input wire o_conv_reset, // hold modulator
    input wire o_irq // interrupt level
);
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);
    // config write lands on the pins two edges on
    pd_switch_follow_a: assert property (i_wr && i_addr == 8'h06
        |-> ##2 o_power_down_switch_on == $past(i_wdata[14], 2))
        else $error("power-down switch does not follow config");
    extra_oe_follow_a: assert property (i_wr && i_addr == 8'h06
        |-> ##2 o_extra_outputs_oe_n ==
        ~($past(i_wdata[13], 2) | $past(i_wdata[12], 2)))
        else $error("extra outputs enable wrong");
    mux_oe_follow_a: assert property (i_wr && i_addr == 8'h06
        |-> ##2 o_general_pins_oe_n == ~$past(i_wdata[12], 2))
        else $error("select pins enable wrong");
    sel_low_bits_a: assert property (!o_general_pins_oe_n
        |-> {o_general_pin_one, o_general_pin_zero} == o_active_chan[1:0])
        else $error("select bits 1..0 differ from channel");
    sel_high_bits_a: assert property (!o_general_pins_oe_n
        |-> {o_extra_output_three, o_extra_output_two} ==
        o_active_chan[3:2])
        else $error("select bits 3..2 differ from channel");
    mux_off_quiet_a: assert property (o_general_pins_oe_n
        |-> !(o_general_pin_zero | o_general_pin_one |
        o_extra_output_two | o_extra_output_three))
        else $error("select lines move with mux control off");
    pair_of_chan_a: assert property (o_conv_start
        |-> o_ain_pair == i_chan_pair[o_active_chan*PW +: PW])
        else $error("input pair is not the channel's own");
    start_enabled_a: assert property (o_conv_start
        |-> i_chan_enable[o_active_chan])
        else $error("conversion on a disabled channel");
    start_single_pulse_a: assert property (o_conv_start
        |=> !o_conv_start ##1 !o_conv_start)
        else $error("start pulses closer than the settle path");
    hold_no_start_a: assert property (o_conv_reset
        |-> !o_conv_start)
        else $error("start while held in reset");
    cover property (o_conv_start);
    cover property (o_conv_reset);
    cover property (o_irq);
endmodule
bind pin_sync_error_control pin_sync_error_control_props #(.NCH(NCH),
    .CW(CW), .PW(PW)) u_props (.i_clk_sys, .i_rst, .i_addr, .i_wdata,
    .i_wr, .i_chan_enable, .i_chan_pair, .o_power_down_switch_on,
    .o_general_pin_zero, .o_general_pin_one, .o_general_pins_oe_n,
    .o_extra_output_two, .o_extra_output_three, .o_extra_outputs_oe_n,
    .o_active_chan, .o_ain_pair, .o_conv_start, .o_conv_reset, .o_irq);

// ==== verification/pin_sync_error_control_tb_top.sv ====
// Purpose: self-checking bench for pin, sync and fault control
// Assumes: other error source held low
// Notes:   reads and channel starts are checked from queues
`timescale 1ns/100ps
module pin_sync_error_control_tb_top;
    reg i_clk_sys = 1'b0;
    reg i_rst = 1'b1;
    reg [7:0] i_addr = 8'h00;
    reg [15:0] i_wdata = 16'h0000;
    reg i_wr = 1'b0;
    reg i_rd = 1'b0;
    reg [15:0] i_chan_enable = 16'h0000;
    reg [63:0] i_chan_pair = 64'h0;
    reg [3:0] i_status_errors = 4'h0;
    reg i_sync_n = 1'b1;
    reg i_ce = 1'b1;
    reg other_low = 1'b0;
    reg slow = 1'b0;
    reg rd_pend = 1'b0;
    reg [31:0] seed = 32'hD1A4;
    reg [63:0] pv;
    reg [15:0] ev;
    wire [15:0] o_rdata;
    wire [3:0] chan, pair;
    wire f_out, f_oe_n, f_lvl, done, pd, g0, g1, g_oe_n, x2, x3, x_oe_n;
    wire start, creset, cerr, irq;
    logic [15:0] rq[$];
    logic [7:0] cq[$];
    integer n_errors = 0, n_checks = 0, n_starts = 0, m, k, w;
    always #10 i_clk_sys = ~i_clk_sys;
    pin_sync_error_control dut (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
        .i_ce(i_ce), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
        .i_rd(i_rd), .o_rdata(o_rdata), .i_chan_enable(i_chan_enable),
        .i_chan_pair(i_chan_pair), .i_conv_done(done),
        .i_other_error(1'b0), .i_status_errors(i_status_errors),
        .i_sync_n(i_sync_n), .i_fault_pin_in(f_lvl),
        .o_fault_pin_out(f_out), .o_fault_pin_oe_n(f_oe_n),
        .o_power_down_switch_on(pd), .o_general_pin_zero(g0),
        .o_general_pin_one(g1), .o_general_pins_oe_n(g_oe_n),
        .o_extra_output_two(x2), .o_extra_output_three(x3),
        .o_extra_outputs_oe_n(x_oe_n), .o_active_chan(chan),
        .o_ain_pair(pair), .o_conv_start(start), .o_conv_reset(creset),
        .o_conv_error(cerr), .o_irq(irq));
    conv_side_model far (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
        .i_slow(slow), .i_conv_start(start), .o_conv_done(done),
        .i_pin_out(f_out), .i_pin_oe_n(f_oe_n), .i_other_low(other_low),
        .o_pin_level(f_lvl));
    function [31:0] xs(input [31:0] x);
        reg [31:0] y;
        begin
            y = x ^ (x << 13);
            y = y ^ (y >> 17);
            xs = y ^ (y << 5);
        end
    endfunction
    task chk(input string nm, input [15:0] e, input [15:0] g);
        begin
            n_checks = n_checks + 1;
            if (g !== e) begin
                n_errors = n_errors + 1;
                $display("BAD %0s exp %h got %h", nm, e, g);
            end
        end
    endtask
    task cyc(input integer n);
        repeat (n) @(posedge i_clk_sys);
    endtask
    // one-cycle strobes with a gap, so a strobe is never set twice at once
    task wr(input [7:0] a, input [15:0] d);
        begin
            i_addr <= a;
            i_wdata <= d;
            i_wr <= 1'b1;
            cyc(1);
            i_wr <= 1'b0;
            cyc(1);
        end
    endtask
    task rd(input [7:0] a, input [15:0] e);
        begin
            rq.push_back(e);
            i_addr <= a;
            i_rd <= 1'b1;
            cyc(1);
            i_rd <= 1'b0;
            cyc(1);
        end
    endtask
    task complete_run;
        begin
            $display("checks %0d errors %0d", n_checks, n_errors);
            if (n_errors == 0 && n_checks > 0)
                $display("All checks passed");
            else
                $display("Checks failed");
            $finish;
        end
    endtask
    // read data sits in the cycle after the strobe; starts pop channels
    always @(posedge i_clk_sys) begin
        rd_pend <= i_rd;
        if (rd_pend && rq.size() > 0)
            chk("rdata", rq.pop_front(), o_rdata);
        if (start === 1'b1) begin
            n_starts <= n_starts + 1;
            if (cq.size() > 0)
                chk("chan_pair", cq.pop_front(), {pair, chan});
        end
    end
    // a hang counts as a mismatch
    initial begin
        #(20 * 6000);
        n_errors = n_errors + 1;
        complete_run;
    end
    initial begin
        cyc(12);
        i_rst <= 1'b0;
        cyc(1);
        rd(8'h06, 16'h0800);
        rd(8'h07, 16'h0000);
        wr(8'h06, 16'h7FFF);
        rd(8'h06, 16'h7F00);
        chk("pd_switch", 16'h1, pd);
        chk("extra_oe_n", 16'h0, x_oe_n);
        chk("mux_oe_n", 16'h0, g_oe_n);
        chk("fault_lvl", 16'h1, f_lvl);
        seed = xs(seed);
        i_status_errors <= seed[3:0] | 4'h1;
        // every fault pin function, with another device pulling low in input mode
        for (m = 0; m < 4; m = m + 1) begin
            other_low <= (m == 1);
            wr(8'h06, {5'h00, m[1:0], 9'h100});
            cyc(8);
            chk("fault_oe_n", (m < 2) ? 16'h1 : 16'h0, f_oe_n);
            if (m == 1) begin
                chk("conv_error", 16'h1, cerr);
                rd(8'h06, 16'h0200);
            end
            if (m > 1)
                chk("fault_out", (m == 3) ? 16'h1 : 16'h0, f_out);
        end
        // converter error event: sticky, masked, then cleared
        rd(8'h08, 16'h0004);
        chk("irq_masked", 16'h0, irq);
        // irq is registered one edge after the mask or status lands
        wr(8'h09, 16'h0004);
        cyc(1);
        chk("irq_on", 16'h1, irq);
        wr(8'h08, 16'h0004);
        cyc(1);
        chk("irq_clear", 16'h0, irq);
        i_status_errors <= 4'h0;
        wr(8'h0A, 16'h0500);
        wr(8'h06, 16'h1800);
        // two passes; the host moves every input pair between them
        for (w = 0; w < 2; w = w + 1) begin
            seed = xs(seed);
            pv[31:0] = seed;
            seed = xs(seed);
            pv[63:32] = seed;
            i_chan_pair <= pv;
            for (k = 0; k < 16; k = k + 5)
                cq.push_back({pv[k*4 +: 4], k[3:0]});
            i_chan_enable <= 16'h8421;
            slow <= (w == 1);
            k = 0;
            while (cq.size() > 0 && k < 400) begin
                cyc(1);
                k = k + 1;
            end
            chk("pass_left", 16'h0, cq.size());
        end
        i_sync_n <= 1'b0;
        cyc(8);
        chk("hold_reset", 16'h1, creset);
        ev = n_starts[15:0];
        cyc(20);
        chk("held_starts", ev, n_starts[15:0]);
        // clock enable low freezes the hold even as sync returns
        i_ce <= 1'b0;
        i_sync_n <= 1'b1;
        cyc(8);
        chk("ce_frozen", 16'h1, creset);
        i_ce <= 1'b1;
        cyc(8);
        chk("hold_free", 16'h0, creset);
        wr(8'h0A, 16'h0501);
        i_sync_n <= 1'b0;
        cyc(40);
        chk("no_reset", 16'h0, creset);
        ev = n_starts[15:0];
        cyc(40);
        chk("wait_starts", ev, n_starts[15:0]);
        i_sync_n <= 1'b1;
        cyc(40);
        chk("resumed", 16'h1, {15'h0, n_starts[15:0] > ev});
        complete_run;
    end
endmodule
